/* File: rtl/rcb_pkg.sv */
// Package with register map, field layout, reset values and timing constants of the reset-cause block.
package rcb_pkg;

    // Register byte offsets.
    localparam logic [7:0] RCB_OFS_FLAGS   = 8'h08;
    localparam logic [7:0] RCB_OFS_BROWNOUT_CONFIG = 8'h14;
    localparam logic [7:0] RCB_OFS_IRQ_ST  = 8'h20;
    localparam logic [7:0] RCB_OFS_IRQ_MSK = 8'h24;
    localparam logic [7:0] RCB_OFS_STATUS  = 8'h28;

    // Reset values.
    localparam logic [7:0]  RCB_FLAGS_RST   = 8'h01;
    localparam logic [31:0] RCB_BROWNOUT_CONFIG_RST = 32'h0000_0002;

    // Flag bit positions.
    localparam int RCB_BIT_POR   = 0;
    localparam int RCB_BIT_BOR   = 1;
    localparam int RCB_BIT_WDT   = 2;
    localparam int RCB_BIT_SWREQ = 3;
    localparam int RCB_BIT_LOCK  = 4;
    localparam int RCB_BIT_PIN   = 5;
    localparam int RCB_BIT_PCOV  = 6;
    localparam int RCB_BIT_PROG  = 7;
    localparam int RCB_NUM_SRC   = 8;

    // Brownout configuration field positions.
    localparam int RCB_DLY_BIT = 1;
    localparam int RCB_VTH_LSB = 2;
    localparam int RCB_VTH_MSB = 4;

    // Brownout trip level codes driven to the analog detector.
    typedef enum logic [2:0] {
        RCB_LVL_2V3 = 3'b000,
        RCB_LVL_2V8 = 3'b001,
        RCB_LVL_3V3 = 3'b010,
        RCB_LVL_3V7 = 3'b011,
        RCB_LVL_4V2 = 3'b100
    } rcb_level_t;

    // Brownout detection delays in nanoseconds, one row per level code from 2.8 V up, 2.3 V sharing the 2.8 V row.
    localparam int RCB_DLY0_NS [4] = '{84000, 97700, 107300, 117300};
    localparam int RCB_DLY1_NS [4] = '{168000, 195900, 215300, 235600};

    // Hold time of the global reset after its source releases.
    localparam int RCB_HOLD_MS = 5;
    localparam int RCB_CLK_NS  = 25;
    localparam int RCB_HOLD_CYC = RCB_HOLD_MS * 1000000 / RCB_CLK_NS;

    // Register bus request.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rcb_bus_req_t;

    // Brownout detector settings.
    typedef struct packed {
        rcb_level_t  level;
        logic        long_delay;
        logic [13:0] delay_cyc;
    } rcb_bor_set_t;

    typedef enum logic [1:0] {
        RCB_ST_RUN  = 2'b00,
        RCB_ST_SRC  = 2'b01,
        RCB_ST_HOLD = 2'b10
    } rcb_state_t;

    function automatic logic [13:0] rcb_ns_to_cyc(input int ns);
        return 14'((ns + RCB_CLK_NS - 1) / RCB_CLK_NS);
    endfunction

endpackage

/* File: rtl/rcb_reset_cause.sv */
// Reset-cause flags, brownout configuration and global reset hold of the chip reset unit.
//
// Operation
// (R1) Flag register at 0x08, resets to 0x1
// (R2) Bit 0 records power-on reset
// (R3) Bit 1 records brownout reset
// (R4) Bit 2 records watchdog reset
// (R5) Bit 3 records software-requested reset
// (R6) Bit 4 records processor lockup reset
// (R7) Bit 5 records external pin reset
// (R8) Bit 6 records program counter range fault
// (R9) Bit 7 records flash programming reset
// (R10) Writing 0 clears a flag; 1 keeps
// (R11) Brownout config at 0x14, resets to 0x2
// (R12) Bits 4:2 select brownout trip level
// (R13) Trip level 2.3 V until programmed
// (R14) Bit 1 selects short or long delay
// (R15) Detection delay depends on both fields
// (R16) Any source holds global reset 5 ms
// (R17) Flags survive reset, accumulate, reserved reads zero
module rcb_reset_cause
    import rcb_pkg::*;
#(
    parameter int HOLD_CYC = RCB_HOLD_CYC
)
(
    // Clock and power-on reset.
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // Register port.
    input  wire logic [7:0]   addr_in,
    input  wire logic [31:0]  wdata_in,
    input  wire logic         wr_in,
    input  wire logic         rd_in,
    output logic      [31:0]  rdata_out,
    // Reset sources, active high while asserted.
    input  wire logic [7:0]   src_in,
    // Chip-wide reset, brownout settings and interrupt.
    output logic              global_rst_n_out,
    output rcb_bor_set_t      bor_set_out,
    output logic              irq_out
);

    initial
    begin
        if (HOLD_CYC < 1 || HOLD_CYC > 2**30)
            $error("HOLD_CYC out of range");
    end

    rcb_bus_req_t req;
    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    logic [7:0]   flags_ff,    nxt_flags;
    logic [2:0]   vth_ff,      nxt_vth;
    logic         dly_ff,      nxt_dly;
    logic         vth_set_ff,  nxt_vth_set;
    logic [7:0]   ist_ff,      nxt_ist;
    logic [7:0]   imsk_ff,     nxt_imsk;
    logic [31:0]  rdata_ff,    nxt_rdata;
    logic         irq_ff,      nxt_irq;
    rcb_bor_set_t bor_ff,      nxt_bor;
    rcb_state_t   state_ff,    nxt_state;
    logic [29:0]  cnt_ff,      nxt_cnt;
    logic         grst_n_ff,   nxt_grst_n;
    logic [7:0]   src_prev_ff;
    logic [7:0]   src_rise;

    // A cause is recorded on the rising edge of its source so a held source does not fight a clear.
    assign src_rise = src_in & ~src_prev_ff;

    // Each flag has its own next-value logic, so a set and a clear in one cycle resolve per bit.
    // The set wins over the clear, so a reset that lands during a clear is never lost.
    for (genvar gi = 0; gi < RCB_NUM_SRC; gi++)
    begin : g_flag
        always_comb
        begin
            nxt_flags[gi] = flags_ff[gi];
            if (req.wr && req.addr == RCB_OFS_FLAGS && !req.wdata[gi])
                nxt_flags[gi] = 1'b0;                                      // R10
            if (src_rise[gi])
                nxt_flags[gi] = 1'b1;                                      // R2 R3 R4 R5 R6 R7 R8 R9 R17
        end
    end

    always_comb
    begin
        nxt_vth     = vth_ff;
        nxt_dly     = dly_ff;
        nxt_vth_set = vth_set_ff;
        nxt_imsk    = imsk_ff;
        nxt_ist     = ist_ff;
        if (req.wr && req.addr == RCB_OFS_BROWNOUT_CONFIG)
        begin
            nxt_vth     = req.wdata[RCB_VTH_MSB:RCB_VTH_LSB];             // R12
            nxt_dly     = req.wdata[RCB_DLY_BIT];                         // R14
            nxt_vth_set = (req.wdata[RCB_VTH_MSB:RCB_VTH_LSB] != 3'b000);  // R13
        end
        else if (req.wr && req.addr == RCB_OFS_IRQ_MSK)
            nxt_imsk = req.wdata[7:0];
        else if (req.wr && req.addr == RCB_OFS_IRQ_ST)
            nxt_ist = ist_ff & ~req.wdata[7:0];
        nxt_ist = nxt_ist | src_rise;
    end

    // Trip level and delay mapping.
    always_comb
    begin
        logic [1:0] row;
        row = 2'b00;
        nxt_bor.long_delay = dly_ff;
        if (!vth_set_ff)
            nxt_bor.level = RCB_LVL_2V3;                                   // R13
        else if (vth_ff[2])
            nxt_bor.level = RCB_LVL_4V2;                                   // R12
        else
            nxt_bor.level = rcb_level_t'(vth_ff);                          // R12
        if (vth_ff[2])
            row = 2'b11;
        else if (vth_ff[1:0] != 2'b00)
            row = vth_ff[1:0] - 2'b01;
        if (dly_ff)
            nxt_bor.delay_cyc = rcb_ns_to_cyc(RCB_DLY1_NS[row]);          // R15
        else
            nxt_bor.delay_cyc = rcb_ns_to_cyc(RCB_DLY0_NS[row]);          // R15
    end

    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (req.rd)
        begin
            if (req.addr == RCB_OFS_FLAGS)
                nxt_rdata = {24'h00_0000, flags_ff};                       // R1 R17
            else if (req.addr == RCB_OFS_BROWNOUT_CONFIG)
                nxt_rdata = {27'h000_0000, vth_ff, dly_ff, 1'b0};          // R11
            else if (req.addr == RCB_OFS_IRQ_ST)
                nxt_rdata = {24'h00_0000, ist_ff};
            else if (req.addr == RCB_OFS_IRQ_MSK)
                nxt_rdata = {24'h00_0000, imsk_ff};
            else if (req.addr == RCB_OFS_STATUS)
                nxt_rdata = {30'h0000_0000, state_ff};
        end
        nxt_irq = |(ist_ff & imsk_ff);
    end

    // Global reset sequencer: held while any source is active, then for the hold time.
    always_comb
    begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_grst_n = grst_n_ff;
        case (state_ff)
            RCB_ST_RUN:
            begin
                nxt_grst_n = 1'b1;
                if (|src_in)
                begin
                    nxt_state  = RCB_ST_SRC;
                    nxt_grst_n = 1'b0;                                     // R16
                end
            end
            RCB_ST_SRC:
            begin
                nxt_grst_n = 1'b0;
                nxt_cnt    = 30'h0000_0000;
                if (!(|src_in))
                    nxt_state = RCB_ST_HOLD;
            end
            RCB_ST_HOLD:
            begin
                nxt_grst_n = 1'b0;
                if (|src_in)
                begin
                    nxt_state = RCB_ST_SRC;
                    nxt_cnt   = 30'h0000_0000;
                end
                else if (cnt_ff == 30'(HOLD_CYC - 1))
                begin
                    nxt_state  = RCB_ST_RUN;                               // R16
                    nxt_grst_n = 1'b1;
                end
                else
                    nxt_cnt = cnt_ff + 30'h0000_0001;
            end
            default:
            begin
                nxt_state = RCB_ST_RUN;
            end
        endcase
    end

    // Flags and configuration reset only with the power-on reset, never with the global reset.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            flags_ff    <= RCB_FLAGS_RST;                                  // R1
            vth_ff      <= RCB_BROWNOUT_CONFIG_RST[RCB_VTH_MSB:RCB_VTH_LSB];       // R11
            dly_ff      <= RCB_BROWNOUT_CONFIG_RST[RCB_DLY_BIT];                   // R11
            vth_set_ff  <= 1'b0;
            ist_ff      <= 8'h00;
            imsk_ff     <= 8'h00;
            rdata_ff    <= 32'h0000_0000;
            irq_ff      <= 1'b0;
            bor_ff      <= '{level: RCB_LVL_2V3, long_delay: 1'b1, delay_cyc: 14'h0000};
            state_ff    <= RCB_ST_HOLD;
            cnt_ff      <= 30'h0000_0000;
            grst_n_ff   <= 1'b0;
            src_prev_ff <= 8'h00;
        end
        else
        begin
            flags_ff    <= nxt_flags;
            vth_ff      <= nxt_vth;
            dly_ff      <= nxt_dly;
            vth_set_ff  <= nxt_vth_set;
            ist_ff      <= nxt_ist;
            imsk_ff     <= nxt_imsk;
            rdata_ff    <= nxt_rdata;
            irq_ff      <= nxt_irq;
            bor_ff      <= nxt_bor;
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            grst_n_ff   <= nxt_grst_n;
            src_prev_ff <= src_in;
        end
    end

    assign rdata_out        = rdata_ff;
    assign irq_out          = irq_ff;
    assign bor_set_out      = bor_ff;
    assign global_rst_n_out = grst_n_ff;

endmodule // rcb_reset_cause

/* File: sim/rcb_reset_cause_properties.sv */
// Concurrent checks on the ports of the reset-cause block.
module rcb_reset_cause_chk
    import rcb_pkg::*;
#(
    parameter int HOLD_CYC = RCB_HOLD_CYC
)
(
    // Every port of the block, all watched.
    input wire logic         clk_in,
    input wire logic         rst_n_in,
    input wire logic [7:0]   addr_in,
    input wire logic [31:0]  wdata_in,
    input wire logic         wr_in,
    input wire logic         rd_in,
    input wire logic [31:0]  rdata_out,
    input wire logic [7:0]   src_in,
    input wire logic         global_rst_n_out,
    input wire rcb_bor_set_t bor_set_out,
    input wire logic         irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // A counter of quiet hold cycles, because the hold is far too long for a delay range.
    int low_cnt_ff;
    int nxt_low_cnt;
    always_comb nxt_low_cnt = (global_rst_n_out || (|src_in)) ? 0 : low_cnt_ff + 1;
    always_ff @(posedge clk_in) low_cnt_ff <= rst_n_in ? nxt_low_cnt : 0;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read slot");
    a_flags_rsvd: assert property ($past(rd_in) && $past(addr_in) == RCB_OFS_FLAGS |-> rdata_out[31:8] == 0)
        else $error("flag reserved bits set");
    a_cfg_rsvd: assert property ($past(rd_in) && $past(addr_in) == RCB_OFS_BROWNOUT_CONFIG |-> !rdata_out[0] && rdata_out[31:5] == 0)
        else $error("config reserved bits set");
    a_src_holds_rst: assert property ((|src_in) && $past(|src_in, 3) |-> !global_rst_n_out)
        else $error("global reset free while source high");
    a_hold_max: assert property (low_cnt_ff <= HOLD_CYC + 2)
        else $error("global reset held too long");
    a_hold_min: assert property ($rose(global_rst_n_out) |-> $past(low_cnt_ff) >= HOLD_CYC - 2)
        else $error("global reset released early");
    a_mask_off: assert property (wr_in && addr_in == RCB_OFS_IRQ_MSK && wdata_in[7:0] == 8'h00 |-> ##2 !irq_out)
        else $error("interrupt high while masked");
    a_cfg_level: assert property (wr_in && addr_in == RCB_OFS_BROWNOUT_CONFIG |-> ##2 bor_set_out.level ==
        ($past(wdata_in[4], 2) ? 3'b100 : {1'b0, $past(wdata_in[3:2], 2)})) else $error("trip level wrong");
    a_cfg_delay: assert property (wr_in && addr_in == RCB_OFS_BROWNOUT_CONFIG |-> ##2 bor_set_out.long_delay ==
        $past(wdata_in[1], 2)) else $error("delay select wrong");
    a_delay_span: assert property ($past(rst_n_in, 2) |-> (bor_set_out.long_delay ?
        bor_set_out.delay_cyc >= 14'd6720 : bor_set_out.delay_cyc <= 14'd4692)) else $error("delay count off");
    c_src: cover property ($fell(global_rst_n_out));
    c_irq: cover property ($rose(irq_out));
    c_cfg: cover property (wr_in && addr_in == RCB_OFS_BROWNOUT_CONFIG);
endmodule // rcb_reset_cause_chk

/* File: sim/rcb_reset_cause_test.sv */
// Self-checking bench of the reset-cause block.
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module rcb_reset_cause_test
    import rcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HC = 20;
    logic         clk_in, rst_n_in, wr_in, rd_in, global_rst_n_out, irq_out;
    logic [7:0]   addr_in, src_in;
    logic [31:0]  wdata_in, rdata_out;
    rcb_bor_set_t bor_set_out;
    int           miscompares, tests_run, n, r, ns;
    rcb_reset_cause #(.HOLD_CYC(HC)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .src_in(src_in),
        .global_rst_n_out(global_rst_n_out), .bor_set_out(bor_set_out), .irq_out(irq_out));
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= w;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 `CHK("rdata", e, rdata_out)
    endtask
    task automatic wait_rel;
        n = 0;
        while (global_rst_n_out !== 1'b1 && n < 200)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        `CHK("hold", 1'b1, n >= HC)
        `CHK("hold_max", 1'b1, n <= HC + 8)
    endtask
    task automatic irqc(input logic e);
        repeat (2) @(posedge clk_in);
        #1 `CHK("irq", e, irq_out)
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #200us;
        miscompares++;
        stop_test;
    end
    initial
    begin
        {rst_n_in, wr_in, rd_in, addr_in, src_in, wdata_in} = '0;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wait_rel();
        rchk(RCB_OFS_FLAGS, 32'h1);
        rchk(RCB_OFS_BROWNOUT_CONFIG, 32'h2);
        `CHK("level", RCB_LVL_2V3, bor_set_out.level)
        rchk(8'h30, 32'h0);
        wr(RCB_OFS_FLAGS, 32'hffff_ffff);
        rchk(RCB_OFS_FLAGS, 32'h1);
        wr(RCB_OFS_FLAGS, 32'hffff_fffe);
        rchk(RCB_OFS_FLAGS, 32'h0);
        wr(RCB_OFS_IRQ_MSK, 32'hff);
        for (int i = 0; i < RCB_NUM_SRC; i++)
        begin
            @(posedge clk_in);
            src_in[i] <= 1'b1;
            repeat (4) @(posedge clk_in);
            src_in[i] <= 1'b0;
            wait_rel();
            rchk(RCB_OFS_FLAGS, (32'h2 << i) - 32'h1);
            `CHK("irq", 1'b1, irq_out)
        end
        rchk(RCB_OFS_IRQ_ST, 32'hff);
        rchk(RCB_OFS_STATUS, 32'h0);
        wr(RCB_OFS_IRQ_MSK, 32'h0);
        irqc(1'b0);
        wr(RCB_OFS_IRQ_MSK, 32'hff);
        irqc(1'b1);
        wr(RCB_OFS_IRQ_ST, 32'hff);
        irqc(1'b0);
        wr(RCB_OFS_FLAGS, 32'hf0);
        rchk(RCB_OFS_FLAGS, 32'hf0);
        for (int k = 0; k < 16; k++)
        begin
            wr(RCB_OFS_BROWNOUT_CONFIG, 32'hffff_ffe1 | (k << 1));
            rchk(RCB_OFS_BROWNOUT_CONFIG, 32'(k << 1));
            r = k[3] ? 3 : (k[3:1] == 0 ? 0 : k[3:1] - 1);
            ns = k[0] ? RCB_DLY1_NS[r] : RCB_DLY0_NS[r];
            `CHK("level", k[3] ? 3'b100 : 3'(k[3:1]), bor_set_out.level)
            `CHK("long", k[0], bor_set_out.long_delay)
            `CHK("delay", 14'((ns + RCB_CLK_NS - 1) / RCB_CLK_NS), bor_set_out.delay_cyc)
        end
        stop_test;
    end
endmodule // rcb_reset_cause_test
bind rcb_reset_cause rcb_reset_cause_chk #(.HOLD_CYC(HOLD_CYC)) u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .src_in(src_in),
    .global_rst_n_out(global_rst_n_out), .bor_set_out(bor_set_out), .irq_out(irq_out));
